// ---- core/watchdog_consts.svh ----
`ifndef WATCHDOG_CONSTS_SVH
`define WATCHDOG_CONSTS_SVH
// What this block does
// R1: 6-bit counter behind 12-bit prescaler
// R2: overflow after 2^13 or 2^18 minus 8
// R3: write to clear address restarts timeout
// R4: clear address reads reset vector low byte
// R5: overflow holds reset low 32 cycles, flags
// R6: monitor mode with high voltage disables
// R7: break with high voltage on reset disables
// R8: stop instruction clears the prescaler
// R9: stop mode freezes prescaler and counter
// R10: prescaler cleared 4096 cycles after power-up
// R11: internal reset clears prescaler and counter
// R12: reset vector fetch clears the prescaler
// R13: disable bit keeps watchdog from resetting
// R14: rate select bit drives long timeout
// R15: interrupt from enabled status flags, besides reset
// R16: keeps counting in wait mode
// R17: stop honoured only when stop enabled
// R18: software clears around stop mode
// R19: overflow request is a single pulse
// register byte addresses
`define WD_CLEAR_ADDR    32'h0000FFFF
`define WD_VECTOR_ADDR   32'h0000FFFC
`define WD_OPTION_ADDR   32'h00000010
`define WD_STATUS_ADDR   32'h00000014
`define WD_IRQ_CLR_ADDR  32'h00000018
`define WD_IRQ_EN_ADDR   32'h0000001C
// option register fields
`define WD_OPT_DISABLE   0
`define WD_OPT_RATE      1
`define WD_OPT_STOP_EN   2
// status fields
`define WD_ST_OVF        0
`define WD_ST_POR        1
// reset values and timing
`define WD_OPTION_RST    8'h00
`define WD_RST_VEC_LOW   8'h00
`define WD_PRE_BITS      12
`define WD_CNT_BITS      6
`define WD_SHORT_TAP     7
`define WD_LONG_TAP      12
`define WD_CLR_MASK      12'h007
`define WD_RST_HOLD      32
`define WD_POR_DELAY     4096
`endif

// ---- core/watchdog_pkg.sv ----
package watchdog_pkg;
  typedef enum logic [1:0] {
    RG_IDLE = 2'b00,
    RG_HOLD = 2'b01
  } rstgen_e;
endpackage

// ---- core/watchdog_core.sv ----
`include "watchdog_consts.svh"
module watchdog_core (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // controls
  input  wire logic       run_i,
  input  wire logic       clr_pre_i,
  input  wire logic       clr_cnt_i,
  input  wire logic       clr_all_i,
  input  wire logic       long_i,
  // overflow pulse
  output logic            ovf_o
);
  logic [`WD_PRE_BITS-1:0] pre_r, pre_nxt;
  logic [`WD_CNT_BITS-1:0] cnt_r, cnt_nxt;
  logic                    tick_r, tick_nxt, ovf_r, ovf_nxt;
  logic [`WD_PRE_BITS-1:0] pre_inc;
  // falling edge of the selected prescaler tap (bit 6 or bit 11) enables the counter
  always_comb begin
    pre_inc  = pre_r + 12'h001;
    pre_nxt  = pre_r;
    cnt_nxt  = cnt_r;
    tick_nxt = tick_r;
    ovf_nxt  = 1'b0;
    if (clr_all_i) begin
      pre_nxt  = '0; // R11
      cnt_nxt  = '0;
      tick_nxt = 1'b0;
    end else if (clr_pre_i) begin
      pre_nxt  = pre_r & `WD_CLR_MASK; // R3 R8 R10 R12
      // forget the old tap level so the masked prescaler gives no false step
      tick_nxt = 1'b0;
      if (clr_cnt_i) cnt_nxt = '0; // R3
    end else if (run_i) begin // R9 R16
      pre_nxt  = pre_inc; // R1
      tick_nxt = long_i ? pre_r[`WD_LONG_TAP-1] : pre_r[`WD_SHORT_TAP-1];
      if (tick_r && !(long_i ? pre_inc[`WD_LONG_TAP-1] : pre_inc[`WD_SHORT_TAP-1]) &&
          (long_i ? pre_r[`WD_LONG_TAP-1] : pre_r[`WD_SHORT_TAP-1]) == 1'b0) begin
        cnt_nxt = cnt_r + 6'h01;
        if (&cnt_r) ovf_nxt = 1'b1; // R2 R19
      end
    end
  end
  // registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre_r  <= '0;
      cnt_r  <= '0;
      tick_r <= 1'b0;
      ovf_r  <= 1'b0;
    end else begin
      pre_r  <= pre_nxt;
      cnt_r  <= cnt_nxt;
      tick_r <= tick_nxt;
      ovf_r  <= ovf_nxt;
    end
  end
  assign ovf_o = ovf_r;
endmodule

// ---- core/watchdog_rstgen.sv ----
`include "watchdog_consts.svh"
module watchdog_rstgen (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // request and pin
  input  wire logic req_i,
  output logic      pin_n_o,
  output logic      busy_o
);
  watchdog_pkg::rstgen_e st_r, st_nxt;
  logic [5:0] cnt_r, cnt_nxt;
  // holds the reset pin low for a fixed count
  always_comb begin
    st_nxt  = st_r;
    cnt_nxt = cnt_r;
    unique case (st_r)
      watchdog_pkg::RG_IDLE: if (req_i) begin
        st_nxt  = watchdog_pkg::RG_HOLD;
        cnt_nxt = 6'h00;
      end
      watchdog_pkg::RG_HOLD: begin
        cnt_nxt = cnt_r + 6'h01;
        if (cnt_r == 6'(`WD_RST_HOLD - 1)) st_nxt = watchdog_pkg::RG_IDLE; // R5
      end
      default: st_nxt = watchdog_pkg::RG_IDLE;
    endcase
  end
  // registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r  <= watchdog_pkg::RG_IDLE;
      cnt_r <= 6'h00;
    end else begin
      st_r  <= st_nxt;
      cnt_r <= cnt_nxt;
    end
  end
  assign pin_n_o = (st_r != watchdog_pkg::RG_HOLD);
  assign busy_o  = (st_r == watchdog_pkg::RG_HOLD);
endmodule

// ---- core/watchdog_counter.sv ----
`include "watchdog_consts.svh"
module watchdog_counter (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [31:0] adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  // cpu events
  input  wire logic        stop_exec_i,
  input  wire logic        wait_mode_i,
  input  wire logic        monitor_mode_i,
  input  wire logic        break_state_i,
  input  wire logic        irq_high_test_voltage_i,
  input  wire logic        rst_high_test_voltage_i,
  // system
  output logic             reset_pin_n_o,
  output logic             watchdog_irq_o
);
  logic [2:0]  option_r, option_nxt;
  logic [1:0]  status_r, status_nxt, irq_en_r, irq_en_nxt;
  logic [31:0] dat_r, dat_nxt;
  logic        ack_r, ack_nxt, stop_r, stop_nxt, irq_r, irq_nxt;
  logic [12:0] por_r, por_nxt;
  logic        por_clr_r, por_clr_nxt, vec_clr_r, vec_clr_nxt;
  logic        acc, wr, rd, clr_wr, inhibit, run, ovf, pin_n, busy;
  logic        pin_r, busy_q;
  logic        long_sel, dis_sel;
  // bus decode
  assign acc      = cyc_i && stb_i && !ack_r;
  assign wr       = acc && we_i;
  assign rd       = acc && !we_i;
  assign clr_wr   = wr && adr_i == `WD_CLEAR_ADDR; // R3
  assign dis_sel  = option_r[`WD_OPT_DISABLE]; // R13
  assign long_sel = option_r[`WD_OPT_RATE]; // R14
  // test voltage inhibits
  assign inhibit  = (monitor_mode_i && (irq_high_test_voltage_i || rst_high_test_voltage_i)) // R6
                 || (break_state_i && rst_high_test_voltage_i); // R7
  // oscillator gated off in stop, kept in wait
  assign run      = !stop_r && !inhibit && !dis_sel; // R9 R16 R13
  watchdog_core u_core (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .run_i     (run),
    .clr_pre_i (stop_exec_i && option_r[`WD_OPT_STOP_EN] || clr_wr || por_clr_r || vec_clr_r),
    .clr_cnt_i (clr_wr), // R3
    .clr_all_i (busy_q),
    .long_i    (long_sel),
    .ovf_o     (ovf)
  );
  watchdog_rstgen u_rstgen (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .req_i   (ovf && !dis_sel), // R19 R13
    .pin_n_o (pin_n),
    .busy_o  (busy)
  );
  // bus, option, status and event state
  always_comb begin
    option_nxt  = option_r;
    status_nxt  = status_r;
    irq_en_nxt  = irq_en_r;
    ack_nxt     = acc;
    dat_nxt     = 32'h00000000;
    stop_nxt    = stop_r;
    por_nxt     = por_r;
    por_clr_nxt = 1'b0;
    vec_clr_nxt = 1'b0;
    if (stop_exec_i && option_r[`WD_OPT_STOP_EN]) stop_nxt = 1'b1; // R17 R8
    if (!wait_mode_i && !stop_exec_i && acc) stop_nxt = 1'b0;
    if (por_r != 13'(`WD_POR_DELAY)) begin
      por_nxt = por_r + 13'h0001;
      if (por_r == 13'(`WD_POR_DELAY - 1)) por_clr_nxt = 1'b1; // R10
    end
    if (rd && adr_i == `WD_VECTOR_ADDR) vec_clr_nxt = 1'b1; // R12
    if (wr && adr_i == `WD_OPTION_ADDR && sel_i[0]) option_nxt = dat_i[2:0];
    if (wr && adr_i == `WD_IRQ_EN_ADDR && sel_i[0]) irq_en_nxt = dat_i[1:0];
    if (wr && adr_i == `WD_IRQ_CLR_ADDR && sel_i[0]) status_nxt = status_r & ~dat_i[1:0];
    if (ovf && !dis_sel) status_nxt[`WD_ST_OVF] = 1'b1; // R5
    if (por_clr_r) status_nxt[`WD_ST_POR] = 1'b1;
    if (rd) begin
      unique case (adr_i)
        `WD_CLEAR_ADDR:  dat_nxt = {24'h000000, `WD_RST_VEC_LOW}; // R4
        `WD_OPTION_ADDR: dat_nxt = {29'h00000000, option_r};
        `WD_STATUS_ADDR: dat_nxt = {30'h00000000, status_r};
        `WD_IRQ_EN_ADDR: dat_nxt = {30'h00000000, irq_en_r};
        default:         dat_nxt = 32'h00000000;
      endcase
    end
    irq_nxt = |(status_nxt & irq_en_nxt); // R15
  end
  // registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      option_r  <= 3'(`WD_OPTION_RST);
      status_r  <= 2'h0;
      irq_en_r  <= 2'h0;
      dat_r     <= 32'h00000000;
      ack_r     <= 1'b0;
      stop_r    <= 1'b0;
      irq_r     <= 1'b0;
      por_r     <= 13'h0000;
      por_clr_r <= 1'b0;
      vec_clr_r <= 1'b0;
      pin_r     <= 1'b1;
      busy_q    <= 1'b0;
    end else begin
      option_r  <= option_nxt;
      status_r  <= status_nxt;
      irq_en_r  <= irq_en_nxt;
      dat_r     <= dat_nxt;
      ack_r     <= ack_nxt;
      stop_r    <= stop_nxt;
      irq_r     <= irq_nxt;
      por_r     <= por_nxt;
      por_clr_r <= por_clr_nxt;
      vec_clr_r <= vec_clr_nxt;
      pin_r     <= pin_n; // R5
      busy_q    <= busy; // R11
    end
  end
  assign dat_o          = dat_r;
  assign ack_o          = ack_r;
  assign reset_pin_n_o  = pin_r;
  assign watchdog_irq_o = irq_r;
endmodule

// ---- bench/watchdog_counter_asserts.sv ----
`include "watchdog_consts.svh"
module watchdog_counter_chk (
  // clock, reset and bus
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [31:0] adr_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  // test voltage, modes and pin
  input wire logic        monitor_mode_i,
  input wire logic        break_state_i,
  input wire logic        irq_high_test_voltage_i,
  input wire logic        rst_high_test_voltage_i,
  input wire logic        reset_pin_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] low_r;
  logic [7:0] low_nxt;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // length of the current low phase of the reset pin
  always_comb low_nxt = reset_pin_n_o ? 8'h00 : low_r + 8'h01;
  always_ff @(posedge clk_i) low_r <= rst_i ? 8'h00 : low_nxt;
  chk_ack_latency: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("ack late");
  chk_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack held");
  chk_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i)) else $error("stray ack");
  chk_vector_read: assert property (
    ack_o && !we_i && adr_i == `WD_CLEAR_ADDR |-> dat_o[7:0] == `WD_RST_VEC_LOW) else $error("vec");
  chk_low_hold: assert property ($rose(reset_pin_n_o) |-> low_r == 8'h20) else $error("short");
  chk_low_max: assert property (low_r <= 8'h20) else $error("long low");
  chk_monitor_off: assert property ($fell(reset_pin_n_o) |->
    !$past(monitor_mode_i && (irq_high_test_voltage_i || rst_high_test_voltage_i)))
    else $error("mon reset");
  chk_break_off: assert property ($fell(reset_pin_n_o) |->
    !$past(break_state_i && rst_high_test_voltage_i)) else $error("brk reset");
endmodule
bind watchdog_counter watchdog_counter_chk watchdog_counter_chk_i (.clk_i, .rst_i, .cyc_i,
  .stb_i, .we_i, .adr_i, .dat_o, .ack_o, .monitor_mode_i, .break_state_i,
  .irq_high_test_voltage_i, .rst_high_test_voltage_i, .reset_pin_n_o);

// ---- bench/reset_sink_model.sv ----
module reset_sink_model (
  // clock and pin
  input  wire logic       clk_i,
  input  wire logic       pin_n_i,
  // last low length
  output logic [7:0]      len_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] run_r;
  // reset sink side: measure each low pulse of the pin
  always_ff @(posedge clk_i) begin
    run_r <= pin_n_i ? 8'h00 : run_r + 8'h01;
    if (pin_n_i && run_r != 8'h00) len_o <= run_r;
  end
endmodule

// ---- bench/watchdog_counter_tb_top.sv ----
`include "watchdog_consts.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module watchdog_counter_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic w; logic [31:0] a; logic [7:0] d; logic [7:0] e;} row_s;
  logic clk_i = 1'h0, rst = 1'h1, cyc = 1'h0, stb = 1'h0, we = 1'h0, stop = 1'h0, wt = 1'h0;
  logic mon = 1'h0, brk = 1'h0, ihv = 1'h0, rhv = 1'h0, ack, pin_n, irq;
  logic [31:0] adr = 32'h0, wdat = 32'h0, rdat, q;
  logic [7:0] len;
  int bad_count = 0, cmp_count = 0, ticks = 0, n;
  row_s rows[6] = '{'{1'h1, `WD_OPTION_ADDR, 8'h00, 8'h00}, '{1'h0, `WD_OPTION_ADDR, 8'h00, 8'h00},
    '{1'h0, `WD_CLEAR_ADDR, 8'h00, `WD_RST_VEC_LOW}, '{1'h0, 32'h00000020, 8'h00, 8'h00},
    '{1'h1, `WD_IRQ_EN_ADDR, 8'h01, 8'h00}, '{1'h0, `WD_IRQ_EN_ADDR, 8'h00, 8'h01}};
  watchdog_counter watchdog_counter_i (.clk_i(clk_i), .rst_i(rst), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(4'h1), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
    .stop_exec_i(stop), .wait_mode_i(wt), .monitor_mode_i(mon), .break_state_i(brk),
    .irq_high_test_voltage_i(ihv), .rst_high_test_voltage_i(rhv), .reset_pin_n_o(pin_n),
    .watchdog_irq_o(irq));
  reset_sink_model reset_sink_model_i (.clk_i(clk_i), .pin_n_i(pin_n), .len_o(len));
  // clock and hang guard
  always #12.5 clk_i = ~clk_i;
  always @(posedge clk_i) if (++ticks == 80000) begin bad_count++; conclude(); end
  task automatic conclude;
    if (bad_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // one classic bus cycle, held until ack
  task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d);
    cyc <= 1'h1; stb <= 1'h1; we <= w; adr <= a; wdat <= d;
    do @(posedge clk_i); while (ack !== 1'h1);
    q = rdat; cyc <= 1'h0; stb <= 1'h0;
    @(posedge clk_i);
  endtask
  // run n cycles, no reset may show
  task automatic quiet(input int n);
    int lows;
    lows = 0;
    repeat (n) begin @(posedge clk_i); if (pin_n !== 1'h1) lows++; end
    `CHK(lows, 0)
  endtask
  initial begin
    repeat (2) @(posedge clk_i);
    rst <= 1'h0;
    @(posedge clk_i);
    `CHK({pin_n, irq}, 2'b10)
    foreach (rows[i]) begin
      wb(rows[i].w, rows[i].a, {24'h0, rows[i].d});
      if (!rows[i].w) `CHK(q[7:0], rows[i].e)
    end
    repeat (3) begin wb(1'h1, `WD_CLEAR_ADDR, 32'h5A); quiet(4000); end
    for (int i = 0; i < 4; i++) begin
      wb(1'h1, `WD_OPTION_ADDR, {29'h0, i == 3, 1'h0, i == 2});
      wb(1'h1, `WD_CLEAR_ADDR, 32'h0);
      mon <= i == 0; ihv <= i == 0; brk <= i == 1; rhv <= i == 1; stop <= i == 3;
      @(posedge clk_i);
      stop <= 1'h0;
      quiet(9000);
      {mon, ihv, brk, rhv} <= 4'h0;
    end
    wb(1'h1, `WD_OPTION_ADDR, 32'h0);
    wb(1'h1, `WD_CLEAR_ADDR, 32'h0);
    stop <= 1'h1; wt <= 1'h1;
    @(posedge clk_i);
    stop <= 1'h0;
    for (n = 0; n < 9000 && pin_n !== 1'h0; n++) @(posedge clk_i);
    `CHK(n > 7000 && n < 9000, 1'h1)
    repeat (40) @(posedge clk_i);
    wt <= 1'h0;
    `CHK(len, 8'h20)
    wb(1'h0, `WD_STATUS_ADDR, 32'h0);
    `CHK({q[0], irq}, 2'b11)
    wb(1'h1, `WD_IRQ_EN_ADDR, 32'h0);
    `CHK(irq, 1'h0)
    wb(1'h1, `WD_IRQ_CLR_ADDR, 32'h1);
    wb(1'h1, `WD_IRQ_EN_ADDR, 32'h1);
    wb(1'h0, `WD_STATUS_ADDR, 32'h0);
    `CHK({q[0], irq}, 2'b00)
    // reset in mid-run: options and outputs back to their reset values
    wb(1'h1, `WD_OPTION_ADDR, 32'h6);
    rst <= 1'h1;
    repeat (2) @(posedge clk_i);
    rst <= 1'h0;
    @(posedge clk_i);
    `CHK({pin_n, irq, ack}, 3'b100)
    wb(1'h0, `WD_OPTION_ADDR, 32'h0);
    `CHK(q[2:0], 3'h0)
    wb(1'h0, `WD_STATUS_ADDR, 32'h0);
    `CHK(q[1:0], 2'h0)
    conclude();
  end
endmodule
